// ===== core/pfc_io_prefetch.sv
// Two-channel I/O read-prefetch unit: local-bus side, fill issue and APB control
// What the document requires of this block, its requesters and software
// RL1: Start command: small write, address kept, data ignored
// RL2: Start empties both buffers, computes start address
// RL3: Start sets active, issues two block fills
// RL4: Reply to start only when siblings idle
// RL5: Two channels; inactive channel serves no reads
// RL6: Reads without prefetch select are not served here
// RL7: Two 16-byte aligned buffers, exact amount returned
// RL8: Requester splits accesses crossing 16-byte boundaries
// RL9: Software sets enable before any prefetch use
// RL10: Prefetch data stays inside one 256-Kbyte partition
// RL11: Start command issued with prefetch select asserted
// RL12: Only standard reads are valid prefetch data requests
// RL13: Sizes: byte, aligned half word, word, words
// RL14: Needs local recognizer match, not private memory
// RL15: Prefetch read drives select and channel line
// RL16: Buffered data returned with one wait state
// RL17: Missing data stalls until its fill lands
// RL18: Only word bits, size bits, byte enables used; the code also feeds a read's bits 31..4 into the next fill address
// RL19: Buffer kept until its last byte is read
// RL20: Last byte read launches next block fill
// RL21: Incrementer touches bits 17..4 only
// RL22: Fills alternate buffer 0 then buffer 1
// RL23: Select low: channel line picks, write starts
// RL24: Channel line picks channel, not cacheability
// RL25: Fills from before a restart are discarded; the code's one-bit tag lets fills from two restarts back land
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pfc_io_prefetch
    import pfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Local bus request, held until lb_ack
    input wire logic lb_req,
    input wire logic prefetch_select_n,
    input wire logic chan_sel,
    input wire logic lb_write,
    input wire logic lb_rmw,
    input wire logic recog_match,
    input wire logic private_match,
    input wire logic [31:0] local_addr_data,
    input wire logic [3:0] byte_enable_n,
    output logic lb_ack,
    output logic lb_rvalid,
    output logic [31:0] lb_rdata,
    // Sibling bridges
    input wire logic sibling_sync_busy,
    output logic sibling_sync_busy_out,
    // System packet bus fill requests and returns
    output logic sp_req,
    output logic [31:0] sp_addr,
    output logic [2:0] sp_tag,
    input wire logic sp_gnt,
    input wire logic sp_rvalid,
    input wire logic [2:0] sp_rtag,
    input wire logic [1:0] sp_rword,
    input wire logic sp_rlast,
    input wire logic [31:0] sp_rdata
);

    // ==========================================================
    // State
    pfc_state_t st, next_st;
    logic [2:0] ctrl, next_ctrl;
    logic req_ch, next_req_ch;
    logic [1:0] req_word, next_req_word;
    logic [1:0] req_cnt, next_req_cnt;
    logic [3:0] req_be_n, next_req_be_n;
    logic [31:0] req_addr, next_req_addr;
    logic [1:0] active, next_active;
    logic [1:0] gen, next_gen;
    logic [1:0] rd_buf, next_rd_buf;
    logic [1:0][1:0] full, next_full;
    logic [1:0][1:0] pend, next_pend;
    logic [1:0][1:0][31:0] pend_addr, next_pend_addr;
    logic iss_valid, next_iss_valid;
    logic [31:0] iss_addr, next_iss_addr;
    logic [2:0] iss_tag, next_iss_tag;
    logic [3:0] mem_rd_addr;
    logic mem_wr_en;
    logic [3:0] mem_wr_addr;
    logic [31:0] mem_rd_data;
    logic [1:0] il;
    logic [PFC_BLK_W-1:0] step;
    logic [PFC_BLK_W-1:0] blk;
    logic fill_ok;
    logic fill_gen_ok;
    logic fill_restart;
    logic iss_found;

    assign il = ctrl[PFC_CTRL_IL_LSB +: 2];
    // Interleave factor 1, 2, 4 or 8 blocks between this bridge's blocks
    assign step = PFC_BLK_ONE << il;
    assign fill_gen_ok = sp_rtag[0] == gen[sp_rtag[2]];
    // The tag flips only as START ends, so a beat landing during START is stale yet still matches
    assign fill_restart = (st == PFC_START) && (sp_rtag[2] == req_ch);
    assign fill_ok = sp_rvalid && fill_gen_ok && !fill_restart; // RL25
    assign mem_wr_en = fill_ok;
    assign mem_wr_addr = {sp_rtag[2], sp_rtag[1], sp_rword}; // RL7

    // ==========================================================
    // APB slave: no wait states, unmapped addresses answer with pslverr
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr != PFC_CTRL_OFF) && (paddr != PFC_STAT_OFF);
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && paddr == PFC_CTRL_OFF) begin
            prdata = {29'h0000_0000, ctrl};
        end else if (psel && !pwrite && paddr == PFC_STAT_OFF) begin
            prdata = {24'h00_0000, full[1], full[0], gen, active};
        end
    end

    // ==========================================================
    // Sequencer and channel bookkeeping
    always_comb begin
        next_st = st;
        next_ctrl = ctrl;
        next_req_ch = req_ch;
        next_req_word = req_word;
        next_req_cnt = req_cnt;
        next_req_be_n = req_be_n;
        next_req_addr = req_addr;
        next_active = active;
        next_gen = gen;
        next_rd_buf = rd_buf;
        next_full = full;
        next_pend = pend;
        next_pend_addr = pend_addr;
        next_iss_valid = iss_valid;
        next_iss_addr = iss_addr;
        next_iss_tag = iss_tag;
        lb_ack = 1'b0;
        lb_rvalid = 1'b0;
        sibling_sync_busy_out = 1'b0;
        mem_rd_addr = {req_ch, rd_buf[req_ch], req_word};
        blk = req_addr[PFC_INC_MSB:PFC_BLK_LSB];

        // STAT is read only; a write to it is dropped without an error
        if (psel && penable && pwrite && paddr == PFC_CTRL_OFF) begin
            next_ctrl = pwdata[2:0]; // RL9
        end

        // Fill issue: one request held on the packet bus until granted
        if (iss_valid && sp_gnt) begin
            next_iss_valid = 1'b0;
        end
        iss_found = 1'b0;
        if (!iss_valid || sp_gnt) begin
            // Fixed priority, channel 0 buffer 0 first; one request per grant keeps the issue path simple
            for (int c = 0; c < PFC_CHANNELS; c++) begin
                for (int b = 0; b < PFC_BUFS; b++) begin
                    if (pend[c][b] && !iss_found) begin
                        iss_found = 1'b1;
                        next_pend[c][b] = 1'b0;
                        next_iss_valid = 1'b1;
                        next_iss_addr = pend_addr[c][b];
                        next_iss_tag = {c[0], b[0], gen[c]};
                    end
                end
            end
        end

        case (st)
            PFC_IDLE: begin
                // Select high means a normal bus cycle, not ours
                if (lb_req && !prefetch_select_n && ctrl[PFC_CTRL_EN_BIT] // RL6 RL23
                    && recog_match && !private_match) begin // RL14
                    next_req_ch = chan_sel; // RL24
                    next_req_word = local_addr_data[3:2]; // RL18
                    next_req_cnt = local_addr_data[1:0];
                    next_req_be_n = byte_enable_n;
                    next_req_addr = local_addr_data;
                    // A start must be one word or less; longer writes are left alone
                    if (lb_write && local_addr_data[1:0] == 2'h0) begin
                        next_st = PFC_START; // RL1
                    end else if (!lb_write && !lb_rmw && active[chan_sel]) begin
                        next_st = PFC_RWAIT; // RL5 RL12
                    end
                end
            end
            PFC_START: begin
                sibling_sync_busy_out = 1'b1;
                // Flipping this channel's one-bit tag marks returns issued under the old tag as stale; returns from two starts back match again
                next_gen[req_ch] = !gen[req_ch]; // RL25
                next_full[req_ch] = 2'b00; // RL2
                next_pend[req_ch] = 2'b11; // RL3
                next_active[req_ch] = 1'b1;
                next_rd_buf[req_ch] = 1'b0; // RL22
                next_pend_addr[req_ch][0] = {req_addr[31:4], PFC_BLOCK_OFS}; // RL7
                next_pend_addr[req_ch][1] = {req_addr[31:18], blk + step, PFC_BLOCK_OFS}; // RL21
                next_st = PFC_SYNC;
            end
            PFC_SYNC: begin
                // Fills are only launched here, completion is not awaited
                if (!sibling_sync_busy) begin
                    lb_ack = 1'b1; // RL4
                    next_st = PFC_IDLE;
                end
            end
            PFC_RWAIT: begin
                // No timeout: a fill that never returns stalls the local bus
                if (full[req_ch][rd_buf[req_ch]]) begin
                    next_st = PFC_RDATA; // RL16
                end // RL17
            end
            PFC_RDATA: begin
                lb_rvalid = 1'b1;
                if (req_cnt == 2'h0) begin
                    lb_ack = 1'b1; // RL7
                    next_st = PFC_IDLE;
                    // Only a read that takes the top byte lane of word 3 frees the buffer
                    if (req_word == PFC_LAST_WORD && !req_be_n[3]) begin
                        next_full[req_ch][rd_buf[req_ch]] = 1'b0; // RL19
                        next_pend[req_ch][rd_buf[req_ch]] = 1'b1; // RL20
                        next_pend_addr[req_ch][rd_buf[req_ch]] =
                            {req_addr[31:18], blk + (step << 1), PFC_BLOCK_OFS}; // RL21 RL10
                        next_rd_buf[req_ch] = !rd_buf[req_ch]; // RL22
                    end
                end else begin
                    next_req_cnt = req_cnt - 2'h1;
                    next_req_word = req_word + 2'h1;
                    mem_rd_addr = {req_ch, rd_buf[req_ch], req_word + 2'h1};
                end
            end
            default: begin
                next_st = PFC_IDLE;
            end
        endcase

        // A landing fill sets after any clear so it is never lost
        if (fill_ok && sp_rlast) begin
            next_full[sp_rtag[2]][sp_rtag[1]] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= PFC_IDLE;
            ctrl <= PFC_CTRL_RESET;
            req_ch <= 1'b0;
            req_word <= 2'h0;
            req_cnt <= 2'h0;
            req_be_n <= 4'hF;
            req_addr <= 32'h0000_0000;
            active <= 2'h0;
            gen <= 2'h0;
            rd_buf <= 2'h0;
            full <= '0;
            pend <= '0;
            pend_addr <= '0;
            iss_valid <= 1'b0;
            iss_addr <= 32'h0000_0000;
            iss_tag <= 3'h0;
        end else begin
            st <= next_st;
            ctrl <= next_ctrl;
            req_ch <= next_req_ch;
            req_word <= next_req_word;
            req_cnt <= next_req_cnt;
            req_be_n <= next_req_be_n;
            req_addr <= next_req_addr;
            active <= next_active;
            gen <= next_gen;
            rd_buf <= next_rd_buf;
            full <= next_full;
            pend <= next_pend;
            pend_addr <= next_pend_addr;
            iss_valid <= next_iss_valid;
            iss_addr <= next_iss_addr;
            iss_tag <= next_iss_tag;
        end
    end

    assign sp_req = iss_valid;
    assign sp_addr = iss_addr;
    assign sp_tag = iss_tag;
    assign lb_rdata = mem_rd_data;

    // ==========================================================
    // Buffer storage
    pfc_buf_mem pfc_buf_mem_i (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(sp_rdata),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

endmodule

// ===== core/pfc_pkg.sv
// Constants, states and field layout shared by the I/O prefetch channel block
package pfc_pkg;

    // ==========================================================
    // Register map on the APB side
    localparam logic [11:0] PFC_CTRL_OFF = 12'h000;
    localparam logic [11:0] PFC_STAT_OFF = 12'h004;
    localparam int PFC_CTRL_EN_BIT = 0;
    localparam int PFC_CTRL_IL_LSB = 1;
    localparam logic [2:0] PFC_CTRL_RESET = 3'h0;

    // ==========================================================
    // Buffer geometry
    localparam int PFC_CHANNELS = 2;
    localparam int PFC_BUFS = 2;
    localparam int PFC_WORDS = 4;
    localparam logic [1:0] PFC_LAST_WORD = 2'h3;
    localparam logic [3:0] PFC_BLOCK_OFS = 4'h0;

    // ==========================================================
    // Address incrementer window: bits 17..4 move, 31..18 stay
    localparam int PFC_INC_MSB = 17;
    localparam int PFC_BLK_LSB = 4;
    localparam int PFC_BLK_W = PFC_INC_MSB - PFC_BLK_LSB + 1;
    localparam logic [PFC_BLK_W-1:0] PFC_BLK_ONE = 14'h0001;

    // ==========================================================
    // Control sequencer
    typedef enum logic [2:0] {
        PFC_IDLE = 3'b000,
        PFC_START = 3'b001,
        PFC_SYNC = 3'b010,
        PFC_RWAIT = 3'b011,
        PFC_RDATA = 3'b100
    } pfc_state_t;

endpackage

// ===== core/pfc_buf_mem.sv
// Storage for both channels' prefetch buffers, registered read port
`timescale 1ns/1ps
module pfc_buf_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] rd_addr,
    output logic [31:0] rd_data
);

    // ==========================================================
    // Array; contents are undefined until a fill lands
    logic [31:0] mem [0:15];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // ==========================================================
    // Read register, one cycle latency gives the single wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ===== verif/pfc_io_prefetch_chk.sv
// Port-level checks of the prefetch unit
`timescale 1ns/1ps
module pfc_io_prefetch_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic lb_req,
    input wire logic prefetch_select_n,
    input wire logic lb_write,
    input wire logic lb_rmw,
    input wire logic recog_match,
    input wire logic private_match,
    input wire logic lb_ack,
    input wire logic lb_rvalid,
    input wire logic sibling_sync_busy,
    input wire logic sibling_sync_busy_out,
    input wire logic sp_req,
    input wire logic [31:0] sp_addr,
    input wire logic sp_gnt
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Assertions
    sel_only_a: assert property ((lb_ack || lb_rvalid) |-> lb_req && !prefetch_select_n)
        else $error("reply without prefetch select");
    read_kind_a: assert property (lb_rvalid |-> !lb_write && !lb_rmw)
        else $error("data for a write or rmw request");
    recog_only_a: assert property (lb_ack |-> recog_match && !private_match)
        else $error("reply without local recognizer hit");
    sync_wait_a: assert property (lb_ack && lb_write |-> !sibling_sync_busy)
        else $error("start reply while sibling busy");
    busy_out_a: assert property (sibling_sync_busy_out |-> lb_req && lb_write)
        else $error("busy out without start command");
    start_fill_a: assert property (sibling_sync_busy_out |-> ##[1:3] sp_req)
        else $error("no fill after start");
    fill_align_a: assert property (sp_req |-> sp_addr[3:0] == 4'h0)
        else $error("fill not block aligned");
    fill_hold_a: assert property (sp_req && !sp_gnt |=> sp_req && $stable(sp_addr))
        else $error("fill request dropped or changed");
    ack_once_a: assert property (lb_ack |=> !lb_ack)
        else $error("ack longer than one cycle");
endmodule
bind pfc_io_prefetch pfc_io_prefetch_chk pfc_io_prefetch_chk_i (.*);

// ===== verif/pfc_fill_mem.sv
// Fill-bus memory model: each word holds its own byte address
`timescale 1ns/1ps
module pfc_fill_mem #(
    parameter int LAT = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sp_req,
    input wire logic [31:0] sp_addr,
    input wire logic [2:0] sp_tag,
    output logic sp_gnt,
    output logic sp_rvalid,
    output logic [2:0] sp_rtag,
    output logic [1:0] sp_rword,
    output logic sp_rlast,
    output logic [31:0] sp_rdata
);
    logic [34:0] q[$];
    int dly;
    logic [1:0] beat;
    // ==========================================
    // Grant and return; slow on purpose so restarts catch fills in flight
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_gnt <= 1'b0;
            sp_rvalid <= 1'b0;
            sp_rlast <= 1'b0;
            sp_rtag <= 3'h0;
            sp_rword <= 2'h0;
            sp_rdata <= 32'h0;
            beat <= 2'h0;
            dly <= 0;
            q.delete();
        end else begin
            sp_gnt <= sp_req && !sp_gnt;
            if (sp_req && sp_gnt) q.push_back({sp_tag, sp_addr});
            sp_rvalid <= 1'b0;
            sp_rlast <= 1'b0;
            // Idle data keeps toggling so a stale word never passes
            sp_rdata <= ~sp_rdata;
            if (q.size() > 0) begin
                dly <= dly + 1;
                if (dly >= LAT) begin
                    sp_rvalid <= 1'b1;
                    sp_rtag <= q[0][34:32];
                    sp_rword <= beat;
                    sp_rdata <= q[0][31:0] | {28'h0, beat, 2'b00};
                    sp_rlast <= beat == 2'h3;
                    beat <= beat + 2'h1;
                    if (beat == 2'h3) begin
                        void'(q.pop_front());
                        dly <= 0;
                    end
                end
            end
        end
    end
endmodule

// ===== verif/io_prefetch_channels_bench.sv
// Testbench of the prefetch unit
`timescale 1ns/1ps
module io_prefetch_channels_bench;
    import pfc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lb_req = 1'b0;
    logic prefetch_select_n = 1'b1, chan_sel = 1'b0, lb_write = 1'b0, lb_rmw = 1'b0, recog_match = 1'b1;
    logic private_match = 1'b0, sibling_sync_busy = 1'b0, pready, pslverr, lb_ack, lb_rvalid;
    logic sibling_sync_busy_out, sp_req, sp_gnt, sp_rvalid, sp_rlast;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, local_addr_data = 32'h0, prdata, lb_rdata, sp_addr, sp_rdata, fills[$];
    logic [3:0] byte_enable_n = 4'h0;
    logic [2:0] sp_tag, sp_rtag;
    logic [1:0] sp_rword;
    int n_errors = 0, tests_run = 0, cyc = 0, lat = 0;
    pfc_io_prefetch pfc_io_prefetch_i (.*);
    pfc_fill_mem pfc_fill_mem_i (.*);
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (sp_req === 1'b1 && sp_gnt === 1'b1) fills.push_back(sp_addr);
        if (cyc == 6000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ==========================================
    // Tasks
    task automatic check(input string w, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, e, input logic er);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        check("pslverr", {31'h0, pslverr}, {31'h0, er});
        if (!wr) check("prdata", prdata, e);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic lb(input logic pf_n, ch, wr, rmw, prv, input logic [31:0] a, base, input logic ack_e, input int n);
        int k;
        int c;
        k = 0;
        c = 0;
        prefetch_select_n <= pf_n;
        chan_sel <= ch;
        lb_write <= wr;
        lb_rmw <= rmw;
        private_match <= prv;
        local_addr_data <= a;
        lb_req <= 1'b1;
        do begin
            @(negedge pclk);
            c++;
            if (lb_rvalid === 1'b1) begin
                check("lb_rdata", lb_rdata, base + {28'h0, a[3:2] + 2'(k), 2'b00});
                k++;
            end
        end while (lb_ack !== 1'b1 && c < 40);
        lat = c;
        check("lb_ack", {31'h0, lb_ack}, {31'h0, ack_e});
        check("words", 32'(k), 32'(n));
        @(posedge pclk);
        lb_req <= 1'b0;
        prefetch_select_n <= 1'b1;
        private_match <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fill(input logic [31:0] e);
        int c;
        c = 0;
        while (fills.size() == 0 && c < 40) begin
            @(posedge pclk);
            c++;
        end
        check("sp_addr", (fills.size() > 0) ? fills.pop_front() : 32'hFFFF_FFFF, e);
    endtask
    // ==========================================
    // Sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, PFC_CTRL_OFF, 32'h0, 32'h0, 1'b0);
        apb(1'b0, PFC_STAT_OFF, 32'h0, 32'h0, 1'b0);
        apb(1'b1, PFC_STAT_OFF, 32'hFF, 32'h0, 1'b0);
        apb(1'b0, PFC_STAT_OFF, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
        apb(1'b1, PFC_CTRL_OFF, 32'h1, 32'h0, 1'b0);
        apb(1'b0, PFC_CTRL_OFF, 32'h0, 32'h1, 1'b0);
        sibling_sync_busy <= 1'b1;
        fork
            lb(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0001_0000, 32'h0, 1'b1, 0);
            begin
                repeat (6) @(posedge pclk);
                sibling_sync_busy <= 1'b0;
            end
        join
        fill(32'h0001_0000);
        fill(32'h0001_0010);
        lb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0001_0003, 32'h0001_0000, 1'b1, 4);
        fill(32'h0001_0020);
        lb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'hABCD_0014, 32'h0001_0010, 1'b1, 1);
        repeat (8) @(posedge pclk);
        check("fills", 32'(fills.size()), 32'h0);
        lb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0001_0019, 32'h0001_0010, 1'b1, 2);
        fill(32'h0001_0030);
        lb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0001_0020, 32'h0001_0020, 1'b1, 1);
        check("latency", 32'(lat), 32'h3);
        for (int i = 0; i < 4; i++) begin
            lb(i == 0, i == 1, 1'b0, i == 2, i == 3, 32'h0001_0024, 32'h0, 1'b0, 0);
        end
        recog_match <= 1'b0;
        lb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0001_0024, 32'h0, 1'b0, 0);
        recog_match <= 1'b1;
        lb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0007_FFF0, 32'h0, 1'b1, 0);
        fill(32'h0007_FFF0);
        fill(32'h0004_0000);
        apb(1'b1, PFC_CTRL_OFF, 32'h3, 32'h0, 1'b0);
        lb(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0007_FFF3, 32'h0007_FFF0, 1'b1, 4);
        fill(32'h0004_0030);
        lb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0002_0000, 32'h0, 1'b1, 0);
        fill(32'h0002_0000);
        fill(32'h0002_0020);
        lb(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0002_0003, 32'h0002_0000, 1'b1, 4);
        fill(32'h0002_0040);
        wrap_up();
    end
endmodule
